// ===== vmsc_top.v
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "vmsc_map.vh"
module vmsc_top #(
  parameter integer SAMPLE_CYCLES = `SAMPLE_MS * `CLK_KHZ  // 40 ms at 25 MHz
) (
  input  wire        CORE_CLK_IN,
  input  wire        NRST_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [7:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  input  wire [7:0]  RX_DATA_IN,
  input  wire        RX_VALID_IN,
  output reg  [7:0]  TX_DATA_OUT,
  output reg         TX_VALID_OUT,
  input  wire        TX_READY_IN,
  input  wire        OPEN_N_IN,
  input  wire        CLOSE_N_IN,
  input  wire        POS_SEL_N_IN,
  input  wire        ILK_DIS_N_IN,
  input  wire        LIMIT_OPEN_IN,
  input  wire        LIMIT_CLOSED_IN,
  input  wire [11:0] SET_ANALOG_IN,
  input  wire [11:0] HI_GAUGE_IN,
  output reg  [1:0]  DRIVE_OUT,
  output reg  [1:0]  MODE_OUT,
  output reg  [13:0] TARGET_OUT,
  output reg         OPEN_LED_OUT,
  output reg         CLOSED_LED_OUT,
  output reg         LO_GAUGE_OUT,
  output reg         INIT_DONE_OUT
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Fold lower case letters onto upper case
  function [7:0] upcase(input [7:0] b);
    upcase = (b >= `CHR_LA && b <= `CHR_LZ) ? b - `CASE_GAP : b;
  endfunction
  // Range value (x100) to code {valid, code}; 0 means absent
  function [4:0] rng_code(input [31:0] v);
    case (v)
      32'h00000000: rng_code = 5'h10;
      32'h0000000A: rng_code = 5'h11;
      32'h00000014: rng_code = 5'h12;
      32'h00000032: rng_code = 5'h13;
      32'h00000064: rng_code = 5'h14;
      32'h000000C8: rng_code = 5'h15;
      32'h000001F4: rng_code = 5'h16;
      32'h000003E8: rng_code = 5'h17;
      32'h00001388: rng_code = 5'h18;
      32'h00002710: rng_code = 5'h19;
      32'h0000C350: rng_code = 5'h1A;
      32'h000186A0: rng_code = 5'h1B;
      default:      rng_code = 5'h00;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Pin synchronisers and 40 ms sampler
  // ----------------------------------------------------------------
  reg  [5:0]  pin_s1_reg;    // First stage, read only by second
  reg  [5:0]  pin_s2_reg;    // {lim_c, lim_o, ilk_n, pos_n, close_n, open_n}
  reg  [3:0]  smp_reg;       // Sampled logic inputs, active low
  reg  [31:0] smp_cnt_reg;   // Sample interval counter
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pin_s1_reg  <= 6'h0F;
      pin_s2_reg  <= 6'h0F;
      smp_reg     <= 4'hF;
      smp_cnt_reg <= 32'h00000000;
    end else begin
      pin_s1_reg <= {LIMIT_CLOSED_IN, LIMIT_OPEN_IN, ILK_DIS_N_IN, POS_SEL_N_IN,
                     CLOSE_N_IN, OPEN_N_IN};
      pin_s2_reg <= pin_s1_reg;
      // Short pulses between samples are missed on purpose
      if (smp_cnt_reg == SAMPLE_CYCLES - 1) begin
        smp_cnt_reg <= 32'h00000000;
        smp_reg     <= pin_s2_reg[3:0];
      end else begin
        smp_cnt_reg <= smp_cnt_reg + 32'h00000001;
      end
    end
  end
  wire ilk_ok = ~smp_reg[3];  // Motion permitted only while held low
  // ----------------------------------------------------------------
  // Serial line parser
  // ----------------------------------------------------------------
  reg  [23:0] let_reg;       // Up to three command letters
  reg  [1:0]  nlet_reg;
  reg  [3:0]  idx_reg;       // First digit: command index
  reg         has_idx_reg;
  reg  [23:0] mant_reg;      // Remaining digits, decimal point dropped
  reg  [3:0]  ndig_reg;
  reg         dot_reg;
  reg  [1:0]  frac_reg;      // Digits after the point, 3 = too many
  reg         bad_reg;       // Line already malformed
  reg         busy_reg;      // Line holds at least one character
  wire [7:0]  ch = upcase(RX_DATA_IN);
  wire        is_term = (ch == `CHR_CR) || (ch == `CHR_LF);
  wire        is_dig  = (ch >= `CHR_D0) && (ch <= `CHR_D9);
  wire        is_let  = (ch >= `CHR_UA) && (ch <= `CHR_UZ);
  wire        exec    = RX_VALID_IN && is_term && busy_reg;
  reg  [31:0] val100;        // Number scaled by 100
  always @* begin
    case (frac_reg)
      2'h0:    val100 = {8'h00, mant_reg} * 32'h00000064;
      2'h1:    val100 = {8'h00, mant_reg} * 32'h0000000A;
      default: val100 = {8'h00, mant_reg};
    endcase
  end
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      let_reg <= 24'h000000; nlet_reg <= 2'h0; idx_reg <= 4'h0;
      has_idx_reg <= 1'b0; mant_reg <= 24'h000000; ndig_reg <= 4'h0;
      dot_reg <= 1'b0; frac_reg <= 2'h0; bad_reg <= 1'b0; busy_reg <= 1'b0;
    end else if (RX_VALID_IN) begin
      if (is_term) begin
        // Lone LF after CR finds an empty line and is ignored
        let_reg <= 24'h000000; nlet_reg <= 2'h0; idx_reg <= 4'h0;
        has_idx_reg <= 1'b0; mant_reg <= 24'h000000; ndig_reg <= 4'h0;
        dot_reg <= 1'b0; frac_reg <= 2'h0; bad_reg <= 1'b0; busy_reg <= 1'b0;
      end else begin
        busy_reg <= 1'b1;
        if (is_let) begin
          // Letters only before any digit
          if (has_idx_reg || nlet_reg == 2'h3) begin
            bad_reg <= 1'b1;
          end else begin
            let_reg  <= {let_reg[15:0], ch};
            nlet_reg <= nlet_reg + 2'h1;
          end
        end else if (is_dig && !has_idx_reg) begin
          idx_reg     <= ch[3:0];
          has_idx_reg <= 1'b1;
        end else if (is_dig) begin
          if (ndig_reg == `NDIG_MAX) begin
            bad_reg <= 1'b1;
          end else begin
            mant_reg <= mant_reg * 24'h00000A + {20'h00000, ch[3:0]};
            ndig_reg <= ndig_reg + 4'h1;
            if (dot_reg && frac_reg != 2'h3) begin
              frac_reg <= frac_reg + 2'h1;
            end
          end
        end else if (ch == `CHR_DOT && has_idx_reg && !dot_reg) begin
          dot_reg <= 1'b1;
        end else begin
          bad_reg <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Command decode and parameter store
  // ----------------------------------------------------------------
  reg  [13:0] gain_reg;      // Loop gain
  reg  [13:0] lead_reg;      // Phase lead, ms
  reg  [3:0]  rng_hi_reg;    // High sensor range code
  reg  [3:0]  rng_lo_reg;    // Low sensor range code
  reg  [1:0]  gsel_reg;      // Gauge selection mode
  reg         ctl_pres_reg;  // Control type: 1 = pressure
  reg  [1:0]  srl_mode_reg;  // Mode requested over serial
  reg  [3:0]  act_idx_reg;   // Active set point
  reg         ok;            // Command accepted
  reg         sp_we;         // Set point write strobe
  wire        num  = (ndig_reg != 4'h0);
  wire        intv = num && !dot_reg;
  wire        nox  = !has_idx_reg && !num && !dot_reg;
  wire [4:0]  rc   = rng_code(val100);
  always @* begin
    ok    = 1'b0;
    sp_we = 1'b0;
    if (!bad_reg && frac_reg != 2'h3) begin
      case (let_reg)
        `CMD_S: begin
          // Index 1..5, 0.00..100.00
          ok    = has_idx_reg && idx_reg >= 4'h1 && idx_reg <= `SP_COUNT && num
                  && val100 <= `SP_MAX;
          sp_we = ok;
        end
        `CMD_T:  ok = has_idx_reg && idx_reg == 4'h1 && intv && ndig_reg == 4'h1
                      && mant_reg <= 24'h000001;
        `CMD_D:  ok = has_idx_reg && idx_reg >= 4'h1 && idx_reg <= `SP_COUNT
                      && !num && !dot_reg;
        `CMD_M, `CMD_SG: ok = has_idx_reg && idx_reg == 4'h1 && intv
                      && val100 >= `GAIN_MIN && val100 <= `PARM_MAX;
        `CMD_X, `CMD_SP: ok = has_idx_reg && idx_reg == 4'h1 && intv
                      && val100 >= `LEAD_MIN && val100 <= `PARM_MAX;
        `CMD_N:  ok = has_idx_reg && (idx_reg == 4'h1 || idx_reg == 4'h2) && num
                      && rc[4];
        `CMD_L:  ok = has_idx_reg && idx_reg <= 4'h2 && !num && !dot_reg;
        `CMD_LO, `CMD_O, `CMD_C: ok = nox;
        default: ok = 1'b0;
      endcase
    end
  end
  // Software reaches none of these: serial is the only path
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      gain_reg     <= `GAIN_RST;
      lead_reg     <= `LEAD_RST;
      rng_hi_reg   <= `RNG_HI_RST;
      rng_lo_reg   <= `RNG_LO_RST;
      gsel_reg     <= `GSEL_HI;
      ctl_pres_reg <= 1'b1;
      srl_mode_reg <= `MODE_OPEN;
      act_idx_reg  <= 4'h1;
    end else if (exec && ok) begin
      case (let_reg)
        `CMD_T:  ctl_pres_reg <= mant_reg[0];
        `CMD_D: begin
          // Activate stored value under current control type
          act_idx_reg  <= idx_reg;
          srl_mode_reg <= ctl_pres_reg ? `MODE_PRES : `MODE_POS;
        end
        `CMD_M, `CMD_SG: gain_reg <= mant_reg[13:0];
        `CMD_X, `CMD_SP: lead_reg <= mant_reg[13:0];
        `CMD_N: begin
          if (idx_reg == 4'h1) begin
            rng_hi_reg <= rc[3:0];
          end else begin
            rng_lo_reg <= rc[3:0];
          end
        end
        `CMD_L:  gsel_reg <= (idx_reg == 4'h1) ? `GSEL_HI :
                             (idx_reg == 4'h2) ? `GSEL_LO : `GSEL_DUAL;
        `CMD_LO: gsel_reg <= `GSEL_DUAL;
        `CMD_O:  srl_mode_reg <= `MODE_OPEN;
        `CMD_C:  srl_mode_reg <= `MODE_CLOSE;
        default: srl_mode_reg <= srl_mode_reg;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Set point store and error reply
  // ----------------------------------------------------------------
  reg  [3:0]  spsel_reg;     // Set point shown on the bus
  wire [13:0] sp_act;        // Active set point value
  wire [13:0] sp_bus;        // Bus-selected set point value
  vmsc_setpt_mem u_mem (
    .clk_in      (CORE_CLK_IN),
    .rst_n_in    (NRST_IN),
    .wr_en_in    (exec && sp_we),
    .wr_idx_in   (idx_reg),
    .wr_data_in  (val100[13:0]),
    .ra_idx_in   (act_idx_reg),
    .ra_data_out (sp_act),
    .rb_idx_in   (spsel_reg),
    .rb_data_out (sp_bus)
  );
  reg         tx_cr_reg;     // Second character of reply pending
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TX_DATA_OUT  <= 8'h00;
      TX_VALID_OUT <= 1'b0;
      tx_cr_reg    <= 1'b0;
    end else if (TX_VALID_OUT && !TX_READY_IN) begin
      TX_VALID_OUT <= 1'b1;  // Hold until taken
    end else if (tx_cr_reg) begin
      TX_DATA_OUT  <= `CHR_CR;
      TX_VALID_OUT <= 1'b1;
      tx_cr_reg    <= 1'b0;
    end else if (exec && !ok && !TX_VALID_OUT) begin
      // Rejected line: a reply in flight drops the new one
      TX_DATA_OUT  <= `CHR_ERR;
      TX_VALID_OUT <= 1'b1;
      tx_cr_reg    <= 1'b1;
    end else begin
      TX_VALID_OUT <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Initialisation sequence and mode selection
  // ----------------------------------------------------------------
  localparam [1:0] ST_WAIT  = 2'h0;  // Waiting for interlock release
  localparam [1:0] ST_CLOSE = 2'h1;  // Seeking closed end
  localparam [1:0] ST_OPEN  = 2'h2;  // Seeking open end
  localparam [1:0] ST_RUN   = 2'h3;  // Normal operation
  reg  [1:0]  st_reg;
  reg  [1:0]  st_next;
  reg         ana_en_reg;    // Analog set value and mode pin in charge
  reg  [1:0]  mode_next;
  reg  [13:0] tgt_next;
  reg  [1:0]  drv_next;
  wire [25:0] ana_quo = ({14'h0000, SET_ANALOG_IN} * `PCT_FULL) / `ANA_FULL;
  wire [13:0] ana_pct = ana_quo[13:0];  // At most 10000
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_WAIT:  st_next = ilk_ok ? ST_CLOSE : ST_WAIT;
      ST_CLOSE: st_next = pin_s2_reg[5] ? ST_OPEN : ST_CLOSE;
      ST_OPEN:  st_next = pin_s2_reg[4] ? ST_RUN : ST_OPEN;
      default:  st_next = ST_RUN;
    endcase
  end
  always @* begin
    // Logic inputs win over serial; close wins over open
    if (!smp_reg[1]) begin
      mode_next = `MODE_CLOSE;
    end else if (!smp_reg[0]) begin
      mode_next = `MODE_OPEN;
    end else if (ana_en_reg) begin
      mode_next = smp_reg[2] ? `MODE_PRES : `MODE_POS;
    end else begin
      mode_next = srl_mode_reg;
    end
    // Values are a share of the high gauge full scale
    tgt_next = (ana_en_reg && smp_reg[1] && smp_reg[0]) ? ana_pct : sp_act;
    case (st_reg)
      ST_CLOSE: drv_next = `DRV_CLOSE;
      ST_OPEN:  drv_next = `DRV_OPEN;
      ST_RUN:   drv_next = (mode_next == `MODE_OPEN)  ? `DRV_OPEN :
                           (mode_next == `MODE_CLOSE) ? `DRV_CLOSE : `DRV_REG;
      default:  drv_next = `DRV_STOP;
    endcase
    if (!ilk_ok) begin
      drv_next = `DRV_STOP;
    end
  end
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_reg         <= ST_WAIT;
      DRIVE_OUT      <= `DRV_STOP;
      MODE_OUT       <= `MODE_OPEN;
      TARGET_OUT     <= 14'h0000;
      OPEN_LED_OUT   <= 1'b1;
      CLOSED_LED_OUT <= 1'b1;
      LO_GAUGE_OUT   <= 1'b0;
      INIT_DONE_OUT  <= 1'b0;
    end else begin
      // Interlock stalls the sequence without losing progress
      if (ilk_ok) begin
        st_reg <= st_next;
      end
      DRIVE_OUT     <= drv_next;
      MODE_OUT      <= (st_reg == ST_RUN) ? mode_next : `MODE_OPEN;
      TARGET_OUT    <= tgt_next;
      INIT_DONE_OUT <= (st_reg == ST_RUN);
      // Both lamps while initialising, end switches afterwards
      OPEN_LED_OUT   <= (st_reg != ST_RUN) || pin_s2_reg[4];
      CLOSED_LED_OUT <= (st_reg != ST_RUN) || pin_s2_reg[5];
      // One gauge live; dual drops to low gauge near bottom of high scale
      case (gsel_reg)
        `GSEL_LO:   LO_GAUGE_OUT <= 1'b1;
        `GSEL_DUAL: LO_GAUGE_OUT <= (rng_lo_reg != 4'h0) && (HI_GAUGE_IN < `DUAL_SW);
        default:    LO_GAUGE_OUT <= 1'b0;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // APB slave: one wait state, unmapped offsets raise PSLVERR
  // ----------------------------------------------------------------
  wire apb_acc = PSEL_IN && PENABLE_IN;
  reg  [31:0] rd_mux;
  reg         rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (PADDR_IN)
      `A_CTRL:   rd_mux = {31'h00000000, ana_en_reg};
      `A_STATUS: rd_mux = {18'h00000, act_idx_reg[2:0], ctl_pres_reg, gsel_reg, ilk_ok,
                           CLOSED_LED_OUT, OPEN_LED_OUT, LO_GAUGE_OUT, MODE_OUT, st_reg};
      `A_GAIN:   rd_mux = {18'h00000, gain_reg};
      `A_LEAD:   rd_mux = {18'h00000, lead_reg};
      `A_RANGE:  rd_mux = {20'h00000, `SPAN_0_10V, `UNIT_TORR, rng_lo_reg, rng_hi_reg};
      `A_SPSEL:  rd_mux = {28'h0000000, spsel_reg};
      `A_SPDATA: rd_mux = {18'h00000, sp_bus};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      PRDATA_OUT  <= 32'h00000000;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      ana_en_reg  <= 1'b0;
      spsel_reg   <= 4'h1;
    end else begin
      PREADY_OUT  <= apb_acc && !PREADY_OUT;
      PSLVERR_OUT <= apb_acc && !PREADY_OUT && !rd_ok;
      PRDATA_OUT  <= (apb_acc && !PREADY_OUT && !PWRITE_IN) ? rd_mux : 32'h00000000;
      // Write lands on the completing edge; parameters stay read-only
      if (apb_acc && PREADY_OUT && PWRITE_IN) begin
        if (PADDR_IN == `A_CTRL) begin
          ana_en_reg <= PWDATA_IN[0];
        end
        if (PADDR_IN == `A_SPSEL) begin
          spsel_reg <= PWDATA_IN[3:0];
        end
      end
    end
  end
endmodule // vmsc_top

// ===== vmsc_map.vh
`ifndef VMSC_MAP_VH
`define VMSC_MAP_VH
// ----------------------------------------------------------------
// Command prefixes, upper case, right justified
// ----------------------------------------------------------------
`define CMD_S     24'h000053
`define CMD_T     24'h000054
`define CMD_D     24'h000044
`define CMD_M     24'h00004D
`define CMD_SG    24'h005347
`define CMD_X     24'h000058
`define CMD_SP    24'h005350
`define CMD_N     24'h00004E
`define CMD_L     24'h00004C
`define CMD_LO    24'h004C4F
`define CMD_O     24'h00004F
`define CMD_C     24'h000043
// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define CHR_CR    8'h0D
`define CHR_LF    8'h0A
`define CHR_DOT   8'h2E
`define CHR_ERR   8'h3F
`define CHR_D0    8'h30
`define CHR_D9    8'h39
`define CHR_UA    8'h41
`define CHR_UZ    8'h5A
`define CHR_LA    8'h61
`define CHR_LZ    8'h7A
`define CASE_GAP  8'h20
// ----------------------------------------------------------------
// Modes, drive codes, gauge selection, unit and span codes
// ----------------------------------------------------------------
`define MODE_POS   2'h0
`define MODE_PRES  2'h1
`define MODE_OPEN  2'h2
`define MODE_CLOSE 2'h3
`define DRV_STOP   2'h0
`define DRV_OPEN   2'h1
`define DRV_CLOSE  2'h2
`define DRV_REG    2'h3
`define GSEL_HI    2'h0
`define GSEL_LO    2'h1
`define GSEL_DUAL  2'h2
`define UNIT_TORR  2'h0
`define SPAN_0_10V 2'h0
// ----------------------------------------------------------------
// Limits and reset values (limits scaled by 100)
// ----------------------------------------------------------------
`define GAIN_MIN   32'h000003E8
`define LEAD_MIN   32'h00000064
`define PARM_MAX   32'h000F4240
`define SP_MAX     32'h00002710
`define SP_COUNT   4'h5
`define GAIN_RST   14'h0064
`define LEAD_RST   14'h0064
`define RNG_HI_RST 4'h7
`define RNG_LO_RST 4'h0
`define DUAL_SW    12'h199
`define ANA_FULL   26'h0000FFF
`define PCT_FULL   26'h0002710
`define NDIG_MAX   4'h7
`define SAMPLE_MS  32'h00000028
`define CLK_KHZ    32'h000061A8
// ----------------------------------------------------------------
// APB byte offsets
// ----------------------------------------------------------------
`define A_CTRL     8'h00
`define A_STATUS   8'h04
`define A_GAIN     8'h08
`define A_LEAD     8'h0C
`define A_RANGE    8'h10
`define A_SPSEL    8'h14
`define A_SPDATA   8'h18
`endif

// ===== vmsc_setpt_mem.v
`timescale 1ns/1ps
// Five set point words, one write port, two registered read ports
module vmsc_setpt_mem (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        wr_en_in,
  input  wire [3:0]  wr_idx_in,
  input  wire [13:0] wr_data_in,
  input  wire [3:0]  ra_idx_in,
  output reg  [13:0] ra_data_out,
  input  wire [3:0]  rb_idx_in,
  output reg  [13:0] rb_data_out
);
  reg [13:0] mem_reg [1:5];  // Indexed 1..5 as software numbers them
  integer    i;

  // ----------------------------------------------------------------
  // Storage and read registers; out-of-range index reads zero
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 1; i <= 5; i = i + 1) begin
        mem_reg[i] <= 14'h0000;
      end
      ra_data_out <= 14'h0000;
      rb_data_out <= 14'h0000;
    end else begin
      // Contents persist until rewritten
      if (wr_en_in && wr_idx_in >= 4'h1 && wr_idx_in <= `SP_COUNT) begin
        mem_reg[wr_idx_in[2:0]] <= wr_data_in;
      end
      if (ra_idx_in >= 4'h1 && ra_idx_in <= `SP_COUNT) begin
        ra_data_out <= mem_reg[ra_idx_in[2:0]];
      end else begin
        ra_data_out <= 14'h0000;
      end
      if (rb_idx_in >= 4'h1 && rb_idx_in <= `SP_COUNT) begin
        rb_data_out <= mem_reg[rb_idx_in[2:0]];
      end else begin
        rb_data_out <= 14'h0000;
      end
    end
  end
endmodule // vmsc_setpt_mem

// ===== vmsc_top_monitor.sv
`timescale 1ns/1ps
module vmsc_mon #(
  parameter integer SAMPLE_CYCLES = 8
) (
  input wire        CORE_CLK_IN,
  input wire        NRST_IN,
  input wire        PSEL_IN,
  input wire        PENABLE_IN,
  input wire [7:0]  PADDR_IN,
  input wire        PREADY_OUT,
  input wire        PSLVERR_OUT,
  input wire [7:0]  TX_DATA_OUT,
  input wire        TX_VALID_OUT,
  input wire        TX_READY_IN,
  input wire        OPEN_N_IN,
  input wire        CLOSE_N_IN,
  input wire        ILK_DIS_N_IN,
  input wire [1:0]  DRIVE_OUT,
  input wire [1:0]  MODE_OUT,
  input wire        OPEN_LED_OUT,
  input wire        CLOSED_LED_OUT,
  input wire        INIT_DONE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Sixteen low cycles cross one tick only while SAMPLE_CYCLES stays under 13
  sequence s_low(sig); (sig == 1'b0)[*8] ##1 (sig == 1'b0)[*8]; endsequence
  sequence s_apb; PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN; endsequence
  chk_init_lamps: assert property (!INIT_DONE_OUT |-> OPEN_LED_OUT && CLOSED_LED_OUT)
    else $error("lamps not both lit during init");
  chk_init_open: assert property ($rose(INIT_DONE_OUT) |-> ##[0:2] MODE_OUT == 2'h2)
    else $error("init did not end in open mode");
  chk_ilk_stop: assert property (s_low(!ILK_DIS_N_IN) |-> DRIVE_OUT == 2'h0)
    else $error("motion with interlock high");
  chk_close_pin: assert property (s_low(CLOSE_N_IN) ##0 INIT_DONE_OUT |-> MODE_OUT == 2'h3)
    else $error("close pin ignored");
  chk_open_pin: assert property (s_low(OPEN_N_IN) ##0 INIT_DONE_OUT |-> MODE_OUT == 2'h2)
    else $error("open pin ignored");
  chk_apb_wait: assert property (s_apb |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not in second access cycle");
  chk_apb_err: assert property (PREADY_OUT && PADDR_IN[1:0] == 2'h0
    |-> PSLVERR_OUT == (PADDR_IN > 8'h18)) else $error("error flag wrong");
  chk_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN
    |=> TX_VALID_OUT && $stable(TX_DATA_OUT)) else $error("reply byte dropped");
  chk_reply_cr: assert property (TX_VALID_OUT && TX_READY_IN && TX_DATA_OUT == 8'h3F
    |=> ##[0:2] TX_VALID_OUT && TX_DATA_OUT == 8'h0D) else $error("reply not ended by CR");
endmodule // vmsc_mon
bind vmsc_top vmsc_mon #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_mon (.CORE_CLK_IN, .NRST_IN,
  .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .TX_DATA_OUT, .TX_VALID_OUT,
  .TX_READY_IN, .OPEN_N_IN, .CLOSE_N_IN, .ILK_DIS_N_IN, .DRIVE_OUT, .MODE_OUT,
  .OPEN_LED_OUT, .CLOSED_LED_OUT, .INIT_DONE_OUT);

// ===== vmsc_host.sv
`timescale 1ns/1ps
module vmsc_host (
  input  wire       clk_in,
  input  wire [1:0] drive_in,
  input  wire       slow_in,
  output reg  [7:0] rx_data_out,
  output reg        rx_valid_out,
  output reg        tx_ready_out,
  output reg        lim_open_out,
  output reg        lim_closed_out
);
  initial begin
    {rx_data_out, rx_valid_out, tx_ready_out} = {8'hA5, 1'b0, 1'b1};
    {lim_open_out, lim_closed_out} = 2'h0;
  end
  // Valve stays at an end until driven away; slow sink stalls replies
  always @(posedge clk_in) begin
    lim_open_out   <= (drive_in === 2'h1) | (lim_open_out & (drive_in !== 2'h2));
    lim_closed_out <= (drive_in === 2'h2) | (lim_closed_out & (drive_in !== 2'h1));
    tx_ready_out   <= slow_in ? 1'($urandom_range(1)) : 1'b1;
  end
  // One byte strobe, then an idle cycle with a changed data line
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_in);
      {rx_data_out, rx_valid_out} <= {s[i], 1'b1};
      @(posedge clk_in);
      {rx_data_out, rx_valid_out} <= {~s[i], 1'b0};
    end
  endtask
endmodule // vmsc_host

// ===== valve_mode_and_setup_control_bench.sv
`timescale 1ns/1ps
module valve_mode_and_setup_control_bench;
  localparam integer SC = 8;  // Short sample period keeps pin tests brief
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, slow = 1'b0;
  logic opn = 1'b1, cls = 1'b1, pos = 1'b1, ilk = 1'b0, pready, perr, rxv, txv, txr, lo, lc;
  logic oled, cled, idone;
  logic [7:0] paddr = 8'h00, rxd, txd;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic [11:0] ana = 12'h000;
  logic [1:0] drv, mode;
  logic [13:0] tgt;
  logic [32:0] expq[$];
  int bad_count = 0, checked = 0, n;
  string cs[8] = '{"m1500\015", "SG19\015", "SG110000\n", "x11\015", "SP110001\015", "N150\015",
                   "n20.1\015\n", "N23\015"};
  bit bd[8] = '{0, 1, 0, 0, 1, 0, 0, 1};
  logic [7:0] ad[8] = '{8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h10};
  logic [31:0] ev[8] = '{32'h1F4, 32'h1F4, 32'h2710, 32'h1, 32'h1, 32'h8, 32'h18, 32'h18};
  always #20 clk = ~clk;
  vmsc_host i_host (.clk_in(clk), .drive_in(drv), .slow_in(slow), .rx_data_out(rxd),
    .rx_valid_out(rxv), .tx_ready_out(txr), .lim_open_out(lo), .lim_closed_out(lc));
  vmsc_top #(.SAMPLE_CYCLES(SC)) i_dut (.CORE_CLK_IN(clk), .NRST_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr), .RX_DATA_IN(rxd),
    .RX_VALID_IN(rxv), .TX_DATA_OUT(txd), .TX_VALID_OUT(txv), .TX_READY_IN(txr),
    .OPEN_N_IN(opn), .CLOSE_N_IN(cls), .POS_SEL_N_IN(pos), .ILK_DIS_N_IN(ilk),
    .LIMIT_OPEN_IN(lo), .LIMIT_CLOSED_IN(lc), .SET_ANALOG_IN(ana), .HI_GAUGE_IN(12'h800),
    .DRIVE_OUT(drv), .MODE_OUT(mode), .TARGET_OUT(tgt), .OPEN_LED_OUT(oled),
    .CLOSED_LED_OUT(cled), .LO_GAUGE_OUT(), .INIT_DONE_OUT(idone));
  task check(input string what, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Read data and replies are matched in order against the notes
  always @(posedge clk) begin
    if ((pready && !pwr) || (txv && txr)) begin
      if (expq.size() == 0) check("queue", 33'h0, 33'h1);
      else check("result", expq.pop_front(), pready ? {perr, prdata} : {25'h0, txd});
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) expq.push_back(e);
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    {psel, pen} <= 2'h0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  task cmd(input string s, input bit bad);
    if (bad) expq = {expq, 33'h3F, 33'h0D};
    i_host.send(s);
    repeat (20) @(posedge clk);
  endtask
  task pins(input logic [1:0] m, input logic [13:0] t);
    @(negedge clk);
    check("mode", {31'h0, m}, {31'h0, mode});
    if (m < 2'h2) begin
      check("drive", 33'h3, {31'h0, drv});
      check("target", {19'h0, t}, {19'h0, tgt});
    end
    @(posedge clk);
  endtask
  initial begin
    v = $urandom(32'hE70A8C55);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 2000 && idone !== 1'b1; n++) @(negedge clk);
    if (n >= 2000) begin bad_count++; tally_and_finish; end
    check("lamps", 33'h2, {31'h0, oled, cled});
    pins(2'h2, 14'h0);
    apb(1'b0, 8'h10, 32'h0, 33'h7);
    apb(1'b0, 8'h40, 32'h0, 33'h100000000);
    $display("test init done");
    slow <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      cmd(cs[k], bd[k]);
      apb(1'b0, ad[k], 32'h0, {1'b0, ev[k]});
    end
    apb(1'b1, 8'h08, 32'h5, 33'h0);
    apb(1'b0, 8'h08, 32'h0, 33'h2710);
    v = $urandom % 10001;
    cmd($sformatf("S1%0d.%02d\015", v / 100, v % 100), 1'b0);
    cmd("s5100\015", 1'b0);
    cmd("S2100.01\015", 1'b1);
    cmd("S61\015", 1'b1);
    apb(1'b0, 8'h18, 32'h0, {1'b0, v});
    apb(1'b1, 8'h14, 32'h5, 33'h0);
    apb(1'b0, 8'h18, 32'h0, 33'h2710);
    $display("test parameters done");
    cmd("C\015", 1'b0);
    pins(2'h3, 14'h0);
    cmd("O\n", 1'b0);
    pins(2'h2, 14'h0);
    cmd("T11\015\nD5\015", 1'b0);
    pins(2'h1, 14'h2710);
    cmd("t10\015d1\015", 1'b0);
    pins(2'h0, v[13:0]);
    $display("test serial modes done");
    cls <= 1'b0;
    cmd("O\015", 1'b0);
    pins(2'h3, 14'h0);
    cls <= 1'b1;
    cmd("C\015", 1'b0);
    opn <= 1'b0;
    repeat (4 * SC) @(posedge clk);
    pins(2'h2, 14'h0);
    opn <= 1'b1;
    v = $urandom % 4096;
    apb(1'b1, 8'h00, 32'h1, 33'h0);
    {pos, ana} <= {1'b0, v[11:0]};
    repeat (4 * SC) @(posedge clk);
    v = v * 32'h2710 / 32'hFFF;
    pins(2'h0, v[13:0]);
    {pos, ana} <= {1'b1, 12'h000};
    repeat (4 * SC) @(posedge clk);
    pins(2'h1, 14'h0);
    ilk <= 1'b1;
    repeat (4 * SC) @(negedge clk);
    check("drive", 33'h0, {31'h0, drv});
    $display("test pins done");
    tally_and_finish;
  end
endmodule // valve_mode_and_setup_control_bench
